// File: pcb_compare_out.sv
// Purpose: Double-buffered compare values and compare output pins of two timers
// Assumes: Counters live outside; countTick marks the last system cycle of each count
// Notes: Channel 16 is the 16-bit timer, channel 8 the 8-bit timer
// How it works
// R01: In PWM, writes to the 16-bit compare value go to a holding buffer.
// R02: At counter top in PWM, holding buffer is copied into active compare.
// R03: 16-bit compare reads return active value before update, also after leaving PWM.
// R04: 8-bit compare reads return the holding buffer contents.
// R05: Disabling compare output mode retains the current pin level.
// R06: Re-enabling compare output resumes from the retained pin level.
// R07: Reset drives every compare output pin to zero.
// R08: Top load in 8/9/10-bit PWM clears high bits above resolution.
// R09: Match acts after the last prescaled count equal to compare value.
// R10: Outside PWM, compare writes update the active value at once.
`include "pcb_defs.svh"
module pcb_compare_out
    import pcb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Counter state
    input wire logic [15:0] count16,
    input wire logic [7:0] count8,
    input wire logic countTick,
    input wire logic pwm16,
    input wire logic [1:0] pwmRes16,
    input wire logic pwm8,
    // Software access
    input wire logic wrCompare16,
    input wire logic [15:0] wdata16,
    input wire logic wrCompare8,
    input wire logic [7:0] wdata8,
    input wire logic [1:0] compareOutputMode16,
    input wire logic [1:0] compareOutputMode8,
    // Read back and pins
    output logic [15:0] compareValueReg16,
    output logic [7:0] compareValueReg8,
    output logic compareOutputPin16,
    output logic compareOutputPin8,
    output logic compareMatch16,
    output logic compareMatch8
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] resMask(input logic [1:0] res);
        unique case (res)
            `PCB_RES_8: resMask = `PCB_MASK_8;
            `PCB_RES_9: resMask = `PCB_MASK_9;
            `PCB_RES_10: resMask = `PCB_MASK_10;
            default: resMask = `PCB_MASK_FULL;
        endcase
    endfunction : resMask

    function automatic logic pinAction(input logic [1:0] mode, input logic pin);
        unique case (mode)
            `PCB_MODE_TOGGLE: pinAction = ~pin;
            `PCB_MODE_CLEAR: pinAction = 1'b0;
            `PCB_MODE_SET: pinAction = 1'b1;
            default: pinAction = pin;
        endcase
    endfunction : pinAction

    // ----------------------------------------
    // State
    // ----------------------------------------
    pcb_state_s st;
    pcb_state_s next_st;
    logic [15:0] top16;
    logic lastCount;
    logic hit16;
    logic hit8;

    always_comb begin
        top16 = `PCB_TOP_FULL & resMask(pwmRes16);
        next_st = st;
        next_st.prevTick = countTick;
        // Tick ends a count: comparing here means the last cycle of it, see R09
        lastCount = countTick;
        hit16 = lastCount && (count16 == st.active16);
        hit8 = lastCount && (count8 == st.active8);
        next_st.match16 = hit16;
        next_st.match8 = hit8;
        // Compare value writes
        if (wrCompare16) begin
            next_st.hold16 = wdata16; // see R01
            if (!pwm16) begin
                next_st.active16 = wdata16; // see R10
            end
        end
        if (pwm16 && lastCount && (count16 == top16)) begin
            next_st.active16 = st.hold16 & resMask(pwmRes16); // see R02, R08
            if (wrCompare16) begin
                next_st.active16 = st.hold16 & resMask(pwmRes16);
            end
        end
        if (wrCompare8) begin
            next_st.hold8 = wdata8;
            if (!pwm8) begin
                next_st.active8 = wdata8; // see R10
            end
        end
        if (pwm8 && lastCount && (count8 == `PCB_TOP_8)) begin
            next_st.active8 = st.hold8; // see R02
        end
        // Pin stays where it was while mode is off, see R05, R06
        if (hit16) begin
            next_st.pin16 = pinAction(compareOutputMode16, st.pin16);
        end
        if (hit8) begin
            next_st.pin8 = pinAction(compareOutputMode8, st.pin8);
        end
        next_st.rdata16 = next_st.active16; // see R01, R03
        next_st.rdata8 = next_st.hold8; // see R04
        if (sys_rst) begin
            next_st = '0; // see R07
        end
    end

    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    assign compareValueReg16 = st.rdata16;
    assign compareValueReg8 = st.rdata8;
    assign compareOutputPin16 = st.pin16;
    assign compareOutputPin8 = st.pin8;
    assign compareMatch16 = st.match16;
    assign compareMatch8 = st.match8;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_pwmWrite;
        pwm16 && wrCompare16 && !(countTick && count16 == top16);
    endsequence

    sequence s_topLoad16;
        pwm16 && countTick && count16 == top16;
    endsequence

    sequence s_toggleHit16;
        hit16 && compareOutputMode16 == `PCB_MODE_TOGGLE;
    endsequence

    a_pwm_write_held: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R01
        s_pwmWrite |=> st.active16 == $past(st.active16))
        else $error("pwm write changed active value");
    a_top_load: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R02
        s_topLoad16 |=> st.active16 == ($past(st.hold16) & $past(top16)))
        else $error("top load missing");
    a_read_active: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R03
        s_pwmWrite |=> compareValueReg16 == $past(compareValueReg16))
        else $error("16-bit read not active value");
    a_read_hold8: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R04
        wrCompare8 |=> compareValueReg8 == $past(wdata8))
        else $error("8-bit read not buffer");
    a_pin_retain: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R05
        compareOutputMode16 == `PCB_MODE_OFF |=> $stable(compareOutputPin16))
        else $error("pin changed while off");
    a_pin_resume: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R06
        s_toggleHit16 |=> compareOutputPin16 != $past(compareOutputPin16))
        else $error("pin did not resume from held level");
    a_reset_pin: assert property (@(posedge sys_clk) // see R07
        sys_rst |=> !compareOutputPin16 && !compareOutputPin8)
        else $error("pin not zero after reset");
    a_res_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R08
        s_topLoad16 |=> (st.active16 & ~$past(top16)) == 16'h0000)
        else $error("high bits not cleared");
    a_last_count: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R09
        compareMatch16 |-> $past(countTick))
        else $error("match not on last count");
    a_direct_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R10
        (!pwm16 && wrCompare16) |=> st.active16 == $past(wdata16))
        else $error("direct write missing");

    a_read_steady: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R03
        (!pwm16 && !wrCompare16) |=> $stable(compareValueReg16))
        else $error("16-bit read changed without write");
    a_match_fires: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R09
        (countTick && count16 == st.active16) |=> compareMatch16)
        else $error("16-bit match missing");

    // ----------------------------------------
    // Channel 8 checks
    // ----------------------------------------
    sequence s_pwmWrite8;
        pwm8 && wrCompare8 && !(countTick && count8 == `PCB_TOP_8);
    endsequence

    sequence s_topLoad8;
        pwm8 && countTick && count8 == `PCB_TOP_8;
    endsequence

    sequence s_toggleHit8;
        hit8 && compareOutputMode8 == `PCB_MODE_TOGGLE;
    endsequence

    a_pwm_hold8: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R01
        s_pwmWrite8 |=> st.active8 == $past(st.active8))
        else $error("8-bit pwm write changed active value");
    a_top_load8: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R02
        s_topLoad8 |=> st.active8 == $past(st.hold8))
        else $error("8-bit top load missing");
    a_direct_write8: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R10
        (!pwm8 && wrCompare8) |=> st.active8 == $past(wdata8))
        else $error("8-bit direct write missing");
    a_pin_retain8: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R05
        compareOutputMode8 == `PCB_MODE_OFF |=> $stable(compareOutputPin8))
        else $error("8-bit pin changed while off");
    a_pin_resume8: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R06
        s_toggleHit8 |=> compareOutputPin8 != $past(compareOutputPin8))
        else $error("8-bit pin did not resume from held level");
    a_match_tick8: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R09
        compareMatch8 |-> st.prevTick)
        else $error("8-bit match not on last count");
    a_match_fires8: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R09
        (countTick && count8 == st.active8) |=> compareMatch8)
        else $error("8-bit match missing");
    a_no_match8: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R09
        !countTick |=> !compareMatch8)
        else $error("8-bit match without count end");
endmodule : pcb_compare_out

// File: pcb_defs.svh
// Purpose: Constants for the compare buffer and output block
// Assumes: Included once per compile unit
// Notes: Mode encodings of the compare output mode field
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH
`define PCB_MODE_OFF 2'h0
`define PCB_MODE_TOGGLE 2'h1
`define PCB_MODE_CLEAR 2'h2
`define PCB_MODE_SET 2'h3
`define PCB_RES_8 2'h1
`define PCB_RES_9 2'h2
`define PCB_RES_10 2'h3
`define PCB_MASK_8 16'h00ff
`define PCB_MASK_9 16'h01ff
`define PCB_MASK_10 16'h03ff
`define PCB_MASK_FULL 16'hffff
`define PCB_TOP_FULL 16'hffff
`define PCB_TOP_8 8'hff
`endif

// File: pcb_pkg.sv
// Purpose: Types for the compare buffer and output block
// Assumes: pcb_defs.svh holds the numbers
// Notes: None
package pcb_pkg;
    typedef struct packed {
        logic [15:0] active16;
        logic [15:0] hold16;
        logic [7:0] active8;
        logic [7:0] hold8;
        logic pin16;
        logic pin8;
        logic [15:0] rdata16;
        logic [7:0] rdata8;
        logic match16;
        logic match8;
        logic prevTick;
    } pcb_state_s;
endpackage : pcb_pkg

// File: testbench.sv
// Purpose: Self-checking bench for pcb_compare_out
// Assumes: Outputs settle at the taking edge, before the next falling edge
// Notes: Inputs change on the falling edge
`include "pcb_defs.svh"
module testbench import pcb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals and table
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic countTick = 1'b0;
    logic pwm16 = 1'b0;
    logic pwm8 = 1'b0;
    logic wrCompare16 = 1'b0;
    logic wrCompare8 = 1'b0;
    logic [15:0] count16 = 16'h0000;
    logic [15:0] wdata16 = 16'h0000;
    logic [7:0] count8 = 8'h00;
    logic [7:0] wdata8 = 8'h00;
    logic [1:0] pwmRes16 = 2'h0;
    logic [1:0] mode16 = 2'h0;
    logic [1:0] mode8 = 2'h0;
    logic [15:0] compareValueReg16;
    logic [7:0] compareValueReg8;
    logic compareOutputPin16;
    logic compareOutputPin8;
    logic compareMatch16;
    logic compareMatch8;
    int n_mismatch = 0;
    int checked = 0;
    int hits16 = 0;
    int hits8 = 0;
    logic [1:0] rowMode [5] = '{`PCB_MODE_SET, `PCB_MODE_CLEAR, `PCB_MODE_TOGGLE,
        `PCB_MODE_OFF, `PCB_MODE_TOGGLE};
    logic rowPin [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [15:0] maskTab [4] = '{`PCB_MASK_FULL, `PCB_MASK_8, `PCB_MASK_9, `PCB_MASK_10};
    logic [15:0] prev = 16'h0005;
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (compareMatch16 === 1'b1) begin
            hits16 <= hits16 + 1;
        end
        if (compareMatch8 === 1'b1) begin
            hits8 <= hits8 + 1;
        end
    end
    pcb_compare_out dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .count16(count16),
        .count8(count8), .countTick(countTick), .pwm16(pwm16), .pwmRes16(pwmRes16),
        .pwm8(pwm8), .wrCompare16(wrCompare16), .wdata16(wdata16),
        .wrCompare8(wrCompare8), .wdata8(wdata8), .compareOutputMode16(mode16),
        .compareOutputMode8(mode8), .compareValueReg16(compareValueReg16),
        .compareValueReg8(compareValueReg8), .compareOutputPin16(compareOutputPin16),
        .compareOutputPin8(compareOutputPin8), .compareMatch16(compareMatch16),
        .compareMatch8(compareMatch8));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] d16, input logic [7:0] d8);
        wrCompare16 = 1'b1;
        wrCompare8 = 1'b1;
        wdata16 = d16;
        wdata8 = d8;
        cyc(1);
        wrCompare16 = 1'b0;
        wrCompare8 = 1'b0;
    endtask : wr
    task automatic tick();
        countTick = 1'b1;
        cyc(1);
        countTick = 1'b0;
        cyc(3);
    endtask : tick
    task automatic give_verdict();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        int h;
        int h8;
        cyc(16);
        sys_rst = 1'b0;
        chk(16'(compareOutputPin16), 16'h0000);
        chk(16'(compareOutputPin8), 16'h0000);
        wr(16'h0005, 8'h05);
        cyc(2);
        chk(compareValueReg16, 16'h0005);
        count16 = 16'h0005;
        count8 = 8'h05;
        for (int i = 0; i < 5; i++) begin
            mode16 = rowMode[i];
            mode8 = rowMode[i];
            h = hits16;
            h8 = hits8;
            cyc(3);
            chk(16'(hits16), 16'(h));
            tick();
            chk(16'(hits16), 16'(h + 1));
            chk(16'(compareOutputPin16), 16'(rowPin[i]));
            chk(16'(compareOutputPin8), 16'(rowPin[i]));
            chk(16'(hits8), 16'(h8 + 1));
        end
        count16 = 16'h0000;
        pwm16 = 1'b1;
        for (int r = 0; r < 4; r++) begin
            pwmRes16 = 2'(r);
            wr(16'hffff, 8'h77);
            cyc(2);
            chk(compareValueReg16, prev);
            count16 = maskTab[r];
            tick();
            chk(compareValueReg16, maskTab[r]);
            prev = maskTab[r];
            count16 = 16'h0000;
        end
        wr(16'h1234, 8'h77);
        pwm16 = 1'b0;
        cyc(3);
        chk(compareValueReg16, prev);
        pwm8 = 1'b1;
        wr(16'h1234, 8'h3c);
        cyc(2);
        chk(16'(compareValueReg8), 16'h003c);
        mode16 = `PCB_MODE_SET;
        count16 = 16'h1234;
        tick();
        chk(16'(compareOutputPin16), 16'h0001);
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        chk(16'(compareOutputPin16), 16'h0000);
        give_verdict();
    end
endmodule : testbench
